// [rtl/poll_out_defines.svh]
`ifndef POLL_OUT_DEFINES_SVH
`define POLL_OUT_DEFINES_SVH

// register byte addresses
`define REG_DEFINE_OUT   12'h000
`define REG_DEFINE_IN    12'h004
`define REG_MODE         12'h008
`define REG_STATUS       12'h00C
`define REG_PIN_OUT      12'h010
`define REG_PIN_DIR      12'h014
`define REG_PIN_IN       12'h018
`define REG_BOUNDARY     12'h01C
`define REG_TRIGGERED    12'h020

// define_polled_output / define_polled_input write layout
`define FLD_PIN_LSB      0
`define FLD_GROUP_BIT    4
`define FLD_LEVEL_BIT    5

// mode values
`define MODE_OFF         4'h0
`define MODE_CONT        4'h2
`define MODE_CONT_RUN    4'h4
`define MODE_LATCH       4'hA
`define MODE_LATCH_RUN   4'hB

// status byte bits
`define ST_OUT_EN        0
`define ST_IN_DEF        1
`define ST_RUN_EN        2
`define ST_LATCH_MODE    3
`define ST_TRIGGERED     4
`define ST_LATCHED       5
`define ST_ACTIVE        7

`define RST_WORD         32'h0000_0000

`endif

// [rtl/poll_out_pkg.sv]
package poll_out_pkg;

   // one pin group: per-pin bits
   typedef struct packed {
      logic [15:0] out_def;
      logic [15:0] out_lvl;
      logic [15:0] in_def;
      logic [15:0] in_lvl;
      logic [15:0] dir;
      logic [15:0] out;
   } group_t;

   typedef struct packed {
      logic [3:0]  mode;
      logic        latched;
      logic        triggered;
      logic        run_req;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } ctrl_t;

endpackage : poll_out_pkg

// [rtl/polled_output_pin_driver.sv]
`timescale 1ns/1ps
`include "poll_out_defines.svh"

// What this block does
// - defining a polled output takes pin 0 to 15, sets it to output
// - each polled output keeps one active level bit, 0 low, 1 high
// - on definition the pin drives the inverse of its active level at once
// - mode picks continuous, latch once, or idle outputs
// - outputs in main and auxiliary groups both act on every event
// - output update and any run-slot switch request register on the same clock edge
// - inputs sampled, outputs updated once per instruction boundary
// - definitions alone start nothing; a polling mode must be selected
// - in continuous modes, with no input at its poll state outputs sit inverse of active level
// - any one defined input at its poll state is a polling event
// - all polled outputs update together, each to its own level
// - mode 2 tracks the input condition at every boundary
// - definitions and mode persist until changed
// - mode 10 changes outputs only once and holds them afterwards
// - status bit 0 output enable, bit 3 latch mode, bit 5 latched
module polled_output_pin_driver
   import poll_out_pkg::*;
#(
   parameter int GROUPS = 2
) (
   input  wire logic        clock_i,
   input  wire logic        sys_rst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        boundary_i,
   input  wire logic        active_group_i,
   input  wire logic [15:0] main_pin_i,
   input  wire logic [15:0] aux_pin_i,
   output logic      [15:0] main_pin_o,
   output logic      [15:0] main_pin_oe_o,
   output logic      [15:0] aux_pin_o,
   output logic      [15:0] aux_pin_oe_o,
   output logic             run_switch_o
);

   // the logic below is written for exactly two pin groups
   if (GROUPS != 2) begin : g_bad_groups
      $error("GROUPS must be 2");
   end

   typedef struct packed {
      group_t [1:0] grp;
      ctrl_t        ctl;
   } state_t;

   state_t st;
   state_t next_st;

   logic [15:0] pin_in [2];
   assign pin_in[0] = main_pin_i;
   assign pin_in[1] = aux_pin_i;

   // decode of the mode values
   function automatic logic out_enabled(input logic [3:0] m);
      return (m == `MODE_CONT) || (m == `MODE_CONT_RUN) ||
             (m == `MODE_LATCH) || (m == `MODE_LATCH_RUN);
   endfunction : out_enabled

   function automatic logic latch_mode(input logic [3:0] m);
      return (m == `MODE_LATCH) || (m == `MODE_LATCH_RUN);
   endfunction : latch_mode

   function automatic logic run_enabled(input logic [3:0] m);
      return (m == `MODE_CONT_RUN) || (m == `MODE_LATCH_RUN);
   endfunction : run_enabled

   logic [7:0] status;
   always_comb begin
      status = 8'h00;
      status[`ST_OUT_EN]     = out_enabled(st.ctl.mode);
      status[`ST_IN_DEF]     = |{st.grp[0].in_def, st.grp[1].in_def};
      status[`ST_RUN_EN]     = run_enabled(st.ctl.mode);
      status[`ST_LATCH_MODE] = latch_mode(st.ctl.mode);
      status[`ST_TRIGGERED]  = st.ctl.triggered;
      status[`ST_LATCHED]    = st.ctl.latched;
      status[`ST_ACTIVE]     = st.ctl.mode != `MODE_OFF;
   end

   logic [3:0]  pin_idx;
   logic        grp_sel;
   logic        lvl;
   logic        setup;
   logic [15:0] hit [2];
   logic        event_now;
   logic        do_update;

   always_comb begin
      next_st = st;
      pin_idx = pwdata_i[`FLD_PIN_LSB +: 4];
      grp_sel = pwdata_i[`FLD_GROUP_BIT];
      lvl     = pwdata_i[`FLD_LEVEL_BIT];
      setup   = psel_i && !penable_i;
      next_st.ctl.run_req = 1'b0;

      // any defined input at its poll state
      for (int g = 0; g < 2; g++) begin
         hit[g] = st.grp[g].in_def & ~(pin_in[g] ^ st.grp[g].in_lvl);
      end
      event_now = |{hit[0], hit[1]};

      // once per boundary; only with outputs enabled
      do_update = boundary_i && out_enabled(st.ctl.mode);
      if (boundary_i && st.ctl.mode != `MODE_OFF) begin
         next_st.ctl.triggered = event_now;
      end

      // latch mode holds once a level is taken
      if (latch_mode(st.ctl.mode) && st.ctl.latched) begin
         do_update = 1'b0;
      end

      if (do_update) begin
         for (int g = 0; g < 2; g++) begin
            for (int p = 0; p < 16; p++) begin
               if (st.grp[g].out_def[p]) begin
                  // active level on event, inverse otherwise
                  next_st.grp[g].out[p] = event_now ?
                     st.grp[g].out_lvl[p] : ~st.grp[g].out_lvl[p];
               end
            end
         end
         if (latch_mode(st.ctl.mode) && event_now) begin
            next_st.ctl.latched = 1'b1;
         end
      end

      // run switch request registers on the same edge as the output update
      if (boundary_i && run_enabled(st.ctl.mode) && event_now) begin
         next_st.ctl.run_req = 1'b1;
      end

      // apb: zero-wait answer, registered at the end of the setup cycle, seen in the first access cycle
      next_st.ctl.pready  = setup;
      next_st.ctl.pslverr = 1'b0;
      if (setup && !pwrite_i) begin
         case (paddr_i)
            `REG_MODE:      next_st.ctl.prdata = {28'h0, st.ctl.mode};
            `REG_STATUS:    next_st.ctl.prdata = {24'h0, status};
            `REG_PIN_OUT:   next_st.ctl.prdata =
               {st.grp[1].out, st.grp[0].out};
            `REG_PIN_DIR:   next_st.ctl.prdata =
               {st.grp[1].dir, st.grp[0].dir};
            `REG_PIN_IN:    next_st.ctl.prdata = {aux_pin_i, main_pin_i};
            `REG_TRIGGERED: next_st.ctl.prdata = {hit[1], hit[0]};
            `REG_DEFINE_OUT: next_st.ctl.prdata =
               {st.grp[1].out_def, st.grp[0].out_def};
            `REG_DEFINE_IN: next_st.ctl.prdata =
               {st.grp[1].in_def, st.grp[0].in_def};
            `REG_BOUNDARY:  next_st.ctl.prdata = 32'h0000_0000;
            default: begin
               next_st.ctl.prdata  = 32'h0000_0000;
               next_st.ctl.pslverr = 1'b1;
            end
         endcase
      end

      // writes take effect at the access edge
      if (psel_i && penable_i && pwrite_i && st.ctl.pready) begin
         case (paddr_i)
            `REG_DEFINE_OUT: begin
               // define, store level, drive inverse now
               next_st.grp[grp_sel].out_def[pin_idx] = 1'b1;
               next_st.grp[grp_sel].out_lvl[pin_idx] = lvl;
               next_st.grp[grp_sel].dir[pin_idx]     = 1'b1;
               next_st.grp[grp_sel].out[pin_idx]     = ~lvl;
            end
            `REG_DEFINE_IN: begin
               next_st.grp[grp_sel].in_def[pin_idx] = 1'b1;
               next_st.grp[grp_sel].in_lvl[pin_idx] = lvl;
               next_st.grp[grp_sel].dir[pin_idx]    = 1'b0;
            end
            `REG_MODE: begin
               next_st.ctl.mode    = pwdata_i[3:0];
               // a latch taken in this same cycle wins over the clear
               if (!(do_update && latch_mode(st.ctl.mode) && event_now)) begin
                  next_st.ctl.latched = 1'b0;
               end
               next_st.ctl.triggered = 1'b0;
            end
            `REG_PIN_OUT: begin
               // program may change a latched pin explicitly
               next_st.grp[0].out = pwdata_i[15:0];
               next_st.grp[1].out = pwdata_i[31:16];
            end
            `REG_PIN_DIR: begin
               next_st.grp[0].dir = pwdata_i[15:0];
               next_st.grp[1].dir = pwdata_i[31:16];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign prdata_o      = st.ctl.prdata;
   assign pready_o      = st.ctl.pready;
   assign pslverr_o     = st.ctl.pslverr;
   assign main_pin_o    = st.grp[0].out;
   assign main_pin_oe_o = st.grp[0].dir;
   assign aux_pin_o     = st.grp[1].out;
   assign aux_pin_oe_o  = st.grp[1].dir;
   assign run_switch_o  = st.ctl.run_req;

   // group select only matters for the program; outputs ignore it
   logic unused_grp;
   assign unused_grp = active_group_i;

endmodule : polled_output_pin_driver

// [tb/pin_load_model.sv]
`timescale 1ns/1ps
// far side: driven pins read back, others show the source
module pin_load_model (
   input  wire logic [15:0] drive_i,
   input  wire logic [15:0] oe_i,
   input  wire logic [15:0] source_i,
   output logic      [15:0] level_o
);
   // the pin driver wins over the outside source
   assign level_o = (oe_i & drive_i) | (~oe_i & source_i);
endmodule : pin_load_model

// [tb/poll_checker.sv]
`timescale 1ns/1ps
`include "poll_out_defines.svh"
module poll_checker (
   input wire logic        clock_i,
   input wire logic        sys_rst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        boundary_i,
   input wire logic [15:0] main_pin_o,
   input wire logic [15:0] main_pin_oe_o,
   input wire logic [15:0] aux_pin_oe_o,
   input wire logic        run_switch_o
);
   logic [3:0] mode_r;
   // mode as written on the bus
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) mode_r <= 4'h0;
      else if (psel_i && penable_i && pready_o && pwrite_i
               && paddr_i == `REG_MODE) mode_r <= pwdata_i[3:0];
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_setup; psel_i && !penable_i; endsequence
   sequence s_def;
      psel_i && penable_i && pready_o && pwrite_i
      && paddr_i == `REG_DEFINE_OUT && !pwdata_i[`FLD_GROUP_BIT];
   endsequence
   property p_ready; s_setup |=> pready_o; endproperty
   property p_once; pready_o |=> !pready_o; endproperty
   property p_err; pslverr_o |-> pready_o && !pwrite_i; endproperty
   property p_def;
      logic [3:0] p;
      logic l;
      (s_def, p = pwdata_i[3:0], l = pwdata_i[5])
         |=> main_pin_oe_o[p] && main_pin_o[p] == !l;
   endproperty
   property p_hold; !boundary_i && !psel_i |=> $stable(main_pin_o); endproperty
   property p_idle;
      mode_r == `MODE_OFF && !psel_i |=> $stable(main_pin_o);
   endproperty
   property p_run; run_switch_o |-> $past(boundary_i); endproperty
   property p_runmode;
      run_switch_o |-> $past(mode_r) == `MODE_CONT_RUN
                    || $past(mode_r) == `MODE_LATCH_RUN;
   endproperty
   property p_rst;
      $fell(sys_rst_i) |-> main_pin_oe_o == 16'h0000 && aux_pin_oe_o == 16'h0000;
   endproperty
   a_ready: assert property (p_ready) else $error("no ready");
   a_once: assert property (p_once) else $error("ready too long");
   a_err: assert property (p_err) else $error("bad error flag");
   a_def: assert property (p_def) else $error("define wrong");
   a_hold: assert property (p_hold) else $error("pins moved");
   a_idle: assert property (p_idle) else $error("idle moved");
   a_run: assert property (p_run) else $error("stray run");
   a_runmode: assert property (p_runmode) else $error("run mode");
   a_rst: assert property (p_rst) else $error("reset oe");
endmodule : poll_checker
bind polled_output_pin_driver poll_checker u_chk (
   .clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .boundary_i(boundary_i), .main_pin_o(main_pin_o),
   .main_pin_oe_o(main_pin_oe_o), .aux_pin_oe_o(aux_pin_oe_o),
   .run_switch_o(run_switch_o));

// [tb/tb_top.sv]
`timescale 1ns/1ps
`include "poll_out_defines.svh"
module tb_top;
   logic        clock_i = 1'b0, sys_rst_i = 1'b1;
   logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, bnd = 1'b0, grp = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rq;
   logic        pready, pslverr, re, run;
   logic [15:0] m_in, a_in, m_out, m_oe, a_out, a_oe;
   logic [15:0] m_src = 16'hFFFF, a_src = 16'hFFDF;
   int          fail_count = 0, n_checks = 0, cyc = 0;
   polled_output_pin_driver u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .boundary_i(bnd), .active_group_i(grp),
      .main_pin_i(m_in), .aux_pin_i(a_in), .main_pin_o(m_out),
      .main_pin_oe_o(m_oe), .aux_pin_o(a_out), .aux_pin_oe_o(a_oe),
      .run_switch_o(run));
   pin_load_model u_main (.drive_i(m_out), .oe_i(m_oe), .source_i(m_src),
      .level_o(m_in));
   pin_load_model u_aux (.drive_i(a_out), .oe_i(a_oe), .source_i(a_src),
      .level_o(a_in));
   initial forever #4 clock_i = ~clock_i;
   // hang guard, far above the roughly 70 cycles needed
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // one bus transfer, held until ready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clock_i);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      pen <= 1'b1;
      n = 0;
      #1;
      // look at ready between edges, never in the launching time step
      while (pready !== 1'b1 && n < 20) begin
         @(posedge clock_i);
         #1;
         n++;
      end
      if (n >= 20) fail_count++;
      // the answer stands until the edge that samples it
      rq = prdata;
      re = pslverr;
      @(posedge clock_i);
      psel <= 1'b0;
      pen <= 1'b0;
      #1;
   endtask : apb
   // pin levels change with the boundary strobe
   task automatic bound(input logic [15:0] m, input logic [15:0] a);
      @(posedge clock_i);
      m_src <= m;
      a_src <= a;
      bnd <= 1'b1;
      @(posedge clock_i);
      bnd <= 1'b0;
      #1;
   endtask : bound
   task automatic t_reset;
      chk(m_oe | a_oe, 32'h0);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk(rq, 32'h0);
      apb(1'b0, 12'h030, 32'h0);
      chk(re, 32'h1);
   endtask : t_reset
   task automatic t_define;
      apb(1'b1, `REG_DEFINE_OUT, 32'h0000_0021);
      chk(m_out & 16'h0002, 32'h0);
      apb(1'b1, `REG_DEFINE_OUT, 32'h0000_0002);
      apb(1'b1, `REG_DEFINE_OUT, 32'h0000_0033);
      apb(1'b1, `REG_DEFINE_IN, 32'h0000_0000);
      chk({m_oe, a_oe}, 32'h0006_0008);
      chk({m_out & 16'h0006, a_out & 16'h0008}, 32'h0004_0000);
      // poll state present, but polling not yet selected
      bound(16'hFFFE, 16'hFFDF);
      chk(m_out & 16'h0006, 32'h4);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk(rq & 32'h3, 32'h2);
   endtask : t_define
   task automatic t_cont;
      apb(1'b1, `REG_MODE, 32'h2);
      apb(1'b1, `REG_DEFINE_IN, 32'h0000_0035);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk(rq & 32'h29, 32'h01);
      grp <= 1'b1;
      bound(16'hFFFE, 16'hFFDF);
      chk({m_out & 16'h0006, a_out & 16'h0008}, 32'h0002_0008);
      bound(16'hFFFF, 16'hFFDF);
      chk({m_out & 16'h0006, a_out & 16'h0008}, 32'h0004_0000);
      bound(16'hFFFE, 16'hFFDF);
      chk(m_out & 16'h0006, 32'h2);
      bound(16'hFFFF, 16'hFFDF);
      chk(m_out & 16'h0006, 32'h4);
   endtask : t_cont
   task automatic t_latch;
      apb(1'b1, `REG_MODE, 32'hA);
      // the aux input alone raises the event
      bound(16'hFFFF, 16'hFFFF);
      chk(m_out & 16'h0006, 32'h2);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk(rq & 32'h29, 32'h29);
      bound(16'hFFFF, 16'hFFDF);
      chk(m_out & 16'h0006, 32'h2);
   endtask : t_latch
   task automatic t_run;
      apb(1'b1, `REG_MODE, 32'h4);
      bound(16'hFFFF, 16'hFFDF);
      chk({m_out & 16'h0006, 15'h0, run}, 32'h0004_0000);
      bound(16'hFFFE, 16'hFFDF);
      chk({m_out & 16'h0006, 15'h0, run}, 32'h0002_0001);
   endtask : t_run
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   initial begin
      repeat (10) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      #1;
      t_reset();
      t_define();
      t_cont();
      t_latch();
      t_run();
      close_out();
   end
endmodule : tb_top
